/* verilog/bdtc_pkg.sv */
// Shared constants and types for the backup-domain time counter.
package bdtc_pkg;

  // Bus geometry: byte address width and register index field.
  localparam int          ADDR_W    = 8;
  localparam int          IDX_LSB   = 2;
  localparam int          IDX_MSB   = 4;
  localparam logic [2:0]  SIZE_WORD = 3'h2;

  // Register word indices; byte offset is four times the index.
  localparam logic [2:0]  IDX_ENABLE  = 3'h0;
  localparam logic [2:0]  IDX_STATUS  = 3'h1;
  localparam logic [2:0]  IDX_PRESC   = 3'h2;
  localparam logic [2:0]  IDX_DIVIDER = 3'h3;
  localparam logic [2:0]  IDX_COUNT   = 3'h4;
  localparam logic [2:0]  IDX_ALARM   = 3'h5;
  localparam logic [2:0]  IDX_CLKSEL  = 3'h6;

  // Field positions in the enable and status words.
  localparam int          FLAG_W   = 3;
  localparam int          BIT_SEC  = 0;
  localparam int          BIT_ALR  = 1;
  localparam int          BIT_OVF  = 2;
  localparam int          BIT_CNF  = 4;
  localparam int          BIT_DONE = 5;

  // Staged-value pending bits.
  localparam int          PEND_PRL = 0;
  localparam int          PEND_CNT = 1;
  localparam int          PEND_ALR = 2;

  // Core tick source selection codes.
  localparam int          SEL_W        = 2;
  localparam logic [1:0]  SEL_SLOW_EXT = 2'h0;
  localparam logic [1:0]  SEL_SLOW_INT = 2'h1;
  localparam logic [1:0]  SEL_FAST_DIV = 2'h2;
  localparam logic [1:0]  SEL_NONE     = 2'h3;

  // Prescaler width (division up to two to the twentieth) and counts.
  localparam int          PRL_W      = 20;
  localparam int          FAST_DIV   = 128;
  localparam int          FAST_DIV_W = $clog2(FAST_DIV);
  localparam int          UPD_TICKS  = 3;
  localparam logic [1:0]  UPD_LAST   = 2'(UPD_TICKS - 1);
  localparam logic [31:0] CNT_MAX    = 32'hffffffff;

  // Update sequencer states.
  typedef enum logic {
    UPD_IDLE = 1'b0,
    UPD_BUSY = 1'b1
  } bdtc_upd_t;

endpackage : bdtc_pkg

/* verilog/bdtc_tick_src.sv */
// Core tick source: source select, fast divider and edge sampling.
`timescale 1ns/10ps
module bdtc_tick_src (
  input  wire logic       hclk,                     // Bus clock.
  input  wire logic       backup_rstn,              // Backup reset, low.
  input  wire logic [1:0] src_sel,                  // Source code.
  input  wire logic       fast_external_oscillator, // Fast source level.
  input  wire logic       slow_external_oscillator, // Slow ext level.
  input  wire logic       slow_internal_oscillator, // Slow int level.
  output logic            core_tick                 // One-cycle tick.
);

  localparam logic [bdtc_pkg::FAST_DIV_W-1:0] DIV_LAST = '1;
  // One step of the fast edge count, sized to the counter.
  localparam logic [bdtc_pkg::FAST_DIV_W-1:0] DIV_ONE  =
    {{(bdtc_pkg::FAST_DIV_W-1){1'b0}}, 1'b1};

  // All state of the tick source.
  typedef struct packed {
    logic                            smp0; // First sampling stage.
    logic                            smp1; // Second sampling stage.
    logic                            last; // Previous sampled level.
    logic [bdtc_pkg::FAST_DIV_W-1:0] div;  // Fast source edge count.
    logic                            tick; // Registered tick pulse.
  } bdtc_src_t;

  bdtc_src_t src_ff;   // Registered state.
  bdtc_src_t nxt_src;  // Next state.
  logic      src_lvl;  // Selected source level.
  logic      rise;     // Rising edge of the sampled source.

  ////////////////////////////////////////////////////////////////////////
  // Source mux; a selection change may yield one spurious edge, which
  // costs at most one tick and is accepted for simplicity.
  always_comb begin
    unique case (src_sel) // [R6]
      bdtc_pkg::SEL_SLOW_EXT: src_lvl = slow_external_oscillator;
      bdtc_pkg::SEL_SLOW_INT: src_lvl = slow_internal_oscillator;
      bdtc_pkg::SEL_FAST_DIV: src_lvl = fast_external_oscillator;
      bdtc_pkg::SEL_NONE:     src_lvl = 1'b0;
    endcase
  end

  // Two-stage sampler; only the second stage feeds the edge detector.
  always_comb begin
    nxt_src      = src_ff;
    nxt_src.smp0 = src_lvl;     // [R20]
    nxt_src.smp1 = src_ff.smp0; // [R20]
    nxt_src.last = src_ff.smp1;
    nxt_src.tick = 1'b0;
    rise         = src_ff.smp1 & ~src_ff.last;
    // The source must be at most a quarter of hclk so no edge is lost.
    if (rise) begin // [R5]
      if (src_sel == bdtc_pkg::SEL_FAST_DIV) begin
        nxt_src.div  = src_ff.div + DIV_ONE; // [R6]
        nxt_src.tick = (src_ff.div == DIV_LAST);
      end else begin
        nxt_src.tick = 1'b1;
      end
    end
  end

  // Cleared only by the backup-domain reset.
  always_ff @(posedge hclk or negedge backup_rstn) begin
    if (!backup_rstn) begin
      src_ff <= '0; // [R8]
    end else begin
      src_ff <= nxt_src;
    end
  end

  assign core_tick = src_ff.tick;

endmodule : bdtc_tick_src

/* verilog/bdtc_core.sv */
// Backup-domain time counter with an AHB-Lite register slave.
//
// What this block does
// [R1] Prescaler divides core ticks by up to 2^20.
// [R2] Thirty-two bit time counter.
// [R3] Prescaler and counter run whenever ticks arrive.
// [R4] Software sets counter; counting continues from it.
// [R5] Core clock at most a quarter of bus clock.
// [R6] Core clock from three selectable sources.
// [R7] System reset clears the bus interface.
// [R8] Core state cleared only by backup reset.
// [R9] Settings and time survive system reset, standby.
// [R10] Core writes blocked until backup unlock.
// [R11] Software enables clocks and unlock before access.
// [R12] Three separately maskable interrupt outputs.
// [R13] Alarm interrupt at programmed time.
// [R14] Periodic second interrupt, prescaler sets period.
// [R15] Overflow interrupt when counter wraps to zero.
// [R16] Second flag on every time-base tick.
// [R17] Counter steps per tick, compared with alarm.
// [R18] Staged values apply after config exit, three ticks.
// [R19] Write-done flag; write only while it reads one.
// [R20] Core events sampled before the bus side uses them.
// [R21] Interrupt equals flag and enable; clears with flag.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module bdtc_core #(
  parameter int AW    = bdtc_pkg::ADDR_W, // Decoded address bits.
  parameter int PRL_W = bdtc_pkg::PRL_W   // Prescaler width.
) (
  input  wire logic          hclk,                     // Bus clock.
  input  wire logic          hresetn,                  // System reset.
  input  wire logic          backup_rstn,              // Backup reset.
  input  wire logic          hsel,                     // Slave select.
  input  wire logic [AW-1:0] haddr,                    // Byte address.
  input  wire logic [1:0]    htrans,                   // Transfer type.
  input  wire logic          hwrite,                   // Write request.
  input  wire logic [2:0]    hsize,                    // Transfer size.
  input  wire logic [31:0]   hwdata,                   // Write data.
  input  wire logic          hready,                   // Bus ready.
  output logic               hreadyout,                // Slave ready.
  output logic               hresp,                    // Response.
  output logic [31:0]        hrdata,                   // Read data.
  input  wire logic          backup_write_unlock,      // Core unlock.
  input  wire logic          fast_external_oscillator, // Fast source.
  input  wire logic          slow_external_oscillator, // Slow ext.
  input  wire logic          slow_internal_oscillator, // Slow int.
  output logic               irq_second,               // Second irq.
  output logic               irq_alarm,                // Alarm irq.
  output logic               irq_overflow              // Overflow irq.
);

  localparam int FW = bdtc_pkg::FLAG_W;

  // Bus-side state, cleared by system reset.
  typedef struct packed {
    logic                 rdy;     // Ready to the bus.
    logic                 err;     // Error response, always OKAY.
    logic [FW-1:0]        en;      // Interrupt enables.
    logic [FW-1:0]        flag;    // Event flags.
    logic                 config_mode_flag;     // Configuration mode.
    bdtc_pkg::bdtc_upd_t  st;      // Update sequencer.
    logic [1:0]           upd_n;   // Ticks seen in this update.
    logic [2:0]           pend;    // Staged values awaiting apply.
    logic [PRL_W-1:0]     stg_prl; // Staged prescaler reload.
    logic [31:0]          stg_cnt; // Staged counter.
    logic [31:0]          stg_alr; // Staged alarm value.
    logic                 wr;      // Write data phase pending.
    logic [2:0]           widx;    // Index of that write.
    logic [31:0]          rdata;   // Read data.
    logic [FW-1:0]        irq;     // Interrupt outputs.
  } bdtc_bus_t;

  // Core state, cleared only by the backup-domain reset.
  typedef struct packed {
    logic [PRL_W-1:0]         prl; // Prescaler reload.
    logic [PRL_W-1:0]         div; // Prescaler down-counter.
    logic [31:0]              cnt; // Time counter.
    logic [31:0]              alr; // Alarm compare value.
    logic [bdtc_pkg::SEL_W-1:0] sel; // Tick source code.
  } bdtc_bk_t;

  localparam bdtc_bus_t BUS_RST = '{rdy: 1'b1,
                                    st: bdtc_pkg::UPD_IDLE,
                                    default: '0};
  localparam bdtc_bk_t  BK_RST  = '{sel: bdtc_pkg::SEL_NONE,
                                    default: '0};

  bdtc_bus_t   bus_ff;   // Bus-side registers.
  bdtc_bus_t   nxt_bus;  // Next bus-side value.
  bdtc_bk_t    bk_ff;    // Core registers.
  bdtc_bk_t    nxt_bk;   // Next core value.
  logic        core_tick; // One-cycle core clock event.
  logic        roll;     // Prescaler terminal tick.
  logic        apply;    // Staged values move into the core now.
  logic        busy;     // Update in progress.
  logic        req;      // Accepted address phase.
  logic [3:0]  dec;      // Hit flag and register index.
  logic [31:0] rd_word;  // Read mux result.
  logic        stage_ok; // Staging write allowed.
  logic [FW-1:0] ev;     // Core events this cycle.

  // Decodes a byte address into {hit, index}.
  function automatic logic [3:0] reg_decode(input logic [AW-1:0] a);
    logic [2:0] idx;
    logic       hit;
    idx = a[bdtc_pkg::IDX_MSB:bdtc_pkg::IDX_LSB];
    hit = (a[AW-1:bdtc_pkg::IDX_MSB+1] == '0) &&
          (a[bdtc_pkg::IDX_LSB-1:0] == '0) &&
          (idx <= bdtc_pkg::IDX_CLKSEL);
    return {hit, idx};
  endfunction : reg_decode

  ////////////////////////////////////////////////////////////////////////
  // Tick source: select, divide and sample the core clock.
  bdtc_tick_src u_src (
    .hclk                     (hclk),
    .backup_rstn              (backup_rstn),
    .src_sel                  (bk_ff.sel),
    .fast_external_oscillator (fast_external_oscillator),
    .slow_external_oscillator (slow_external_oscillator),
    .slow_internal_oscillator (slow_internal_oscillator),
    .core_tick                (core_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Core events and the update strobe.
  assign busy  = (bus_ff.st == bdtc_pkg::UPD_BUSY);
  assign roll  = core_tick && (bk_ff.div == '0);             // [R1]
  assign apply = busy && core_tick &&
                 (bus_ff.upd_n == bdtc_pkg::UPD_LAST);       // [R18]
  assign ev[bdtc_pkg::BIT_SEC] = roll;                       // [R16]
  assign ev[bdtc_pkg::BIT_ALR] = roll && (bk_ff.cnt == bk_ff.alr);
  assign ev[bdtc_pkg::BIT_OVF] = roll &&
                                 (bk_ff.cnt == bdtc_pkg::CNT_MAX);
  assign req = hsel && htrans[1] && hready &&
               (hsize == bdtc_pkg::SIZE_WORD);
  assign dec = reg_decode(haddr);
  // Staging needs unlock, configuration mode and an idle sequencer.
  assign stage_ok = backup_write_unlock && bus_ff.config_mode_flag && !busy; // [R10]

  ////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits and unmapped words read as zero.
  always_comb begin
    rd_word = '0;
    unique case (dec[2:0])
      bdtc_pkg::IDX_ENABLE: rd_word[FW-1:0] = bus_ff.en;
      bdtc_pkg::IDX_STATUS: begin
        rd_word[FW-1:0]           = bus_ff.flag;
        rd_word[bdtc_pkg::BIT_CNF]  = bus_ff.config_mode_flag;
        rd_word[bdtc_pkg::BIT_DONE] = !busy; // [R19]
      end
      bdtc_pkg::IDX_PRESC:   rd_word[PRL_W-1:0] = bk_ff.prl;
      bdtc_pkg::IDX_DIVIDER: rd_word[PRL_W-1:0] = bk_ff.div;
      bdtc_pkg::IDX_COUNT:   rd_word = bk_ff.cnt;
      bdtc_pkg::IDX_ALARM:   rd_word = bk_ff.alr;
      bdtc_pkg::IDX_CLKSEL:  rd_word[bdtc_pkg::SEL_W-1:0] = bk_ff.sel;
      default:               rd_word = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus side: zero-wait slave, staging, update sequencer and flags.
  always_comb begin
    nxt_bus       = bus_ff;
    nxt_bus.rdy   = 1'b1;
    nxt_bus.err   = 1'b0;
    nxt_bus.wr    = req && hwrite && dec[3];
    nxt_bus.widx  = dec[2:0];
    nxt_bus.rdata = (req && !hwrite && dec[3]) ? rd_word : '0;
    // The sequencer counts core ticks; the third one applies.
    unique case (bus_ff.st)
      bdtc_pkg::UPD_IDLE: ;
      bdtc_pkg::UPD_BUSY: begin
        if (apply) begin // [R18]
          nxt_bus.st   = bdtc_pkg::UPD_IDLE;
          nxt_bus.pend = '0;
          nxt_bus.upd_n = '0;
        end else if (core_tick) begin
          nxt_bus.upd_n = bus_ff.upd_n + 2'h1;
        end
      end
    endcase
    if (bus_ff.wr) begin
      unique case (bus_ff.widx)
        bdtc_pkg::IDX_ENABLE: begin
          // Enables are frozen while an update completes.
          if (!busy) begin // [R19]
            nxt_bus.en = hwdata[FW-1:0];
          end
        end
        bdtc_pkg::IDX_STATUS: begin
          nxt_bus.flag = bus_ff.flag & hwdata[FW-1:0];
          nxt_bus.config_mode_flag  = hwdata[bdtc_pkg::BIT_CNF];
          // Leaving configuration mode with values staged starts the update.
          if (bus_ff.config_mode_flag && !hwdata[bdtc_pkg::BIT_CNF] &&
              (bus_ff.pend != '0) && !busy) begin // [R18]
            nxt_bus.st    = bdtc_pkg::UPD_BUSY;
            nxt_bus.upd_n = '0;
          end
        end
        bdtc_pkg::IDX_PRESC: begin
          if (stage_ok) begin // [R10]
            nxt_bus.stg_prl = hwdata[PRL_W-1:0];
            nxt_bus.pend[bdtc_pkg::PEND_PRL] = 1'b1;
          end
        end
        bdtc_pkg::IDX_COUNT: begin
          if (stage_ok) begin // [R4]
            nxt_bus.stg_cnt = hwdata;
            nxt_bus.pend[bdtc_pkg::PEND_CNT] = 1'b1;
          end
        end
        bdtc_pkg::IDX_ALARM: begin
          if (stage_ok) begin // [R13]
            nxt_bus.stg_alr = hwdata;
            nxt_bus.pend[bdtc_pkg::PEND_ALR] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    nxt_bus.flag = nxt_bus.flag | ev;           // [R14] [R15]
    nxt_bus.irq  = nxt_bus.flag & nxt_bus.en;   // [R12] [R21]
  end

  ////////////////////////////////////////////////////////////////////////
  // Core: prescaler chain, counter and staged loads.
  always_comb begin
    nxt_bk = bk_ff;
    if (roll) begin // [R3]
      nxt_bk.div = bk_ff.prl;                   // [R1]
      nxt_bk.cnt = bk_ff.cnt + 32'h1;           // [R2] [R17]
    end else if (core_tick) begin
      nxt_bk.div = bk_ff.div - PRL_W'(1);
    end
    if (apply) begin
      if (bus_ff.pend[bdtc_pkg::PEND_PRL]) begin
        nxt_bk.prl = bus_ff.stg_prl;
        nxt_bk.div = bus_ff.stg_prl;
      end
      if (bus_ff.pend[bdtc_pkg::PEND_CNT]) begin
        nxt_bk.cnt = bus_ff.stg_cnt;            // [R4]
      end
      if (bus_ff.pend[bdtc_pkg::PEND_ALR]) begin
        nxt_bk.alr = bus_ff.stg_alr;
      end
    end
    if (bus_ff.wr && (bus_ff.widx == bdtc_pkg::IDX_CLKSEL) &&
        backup_write_unlock) begin // [R10]
      nxt_bk.sel = hwdata[bdtc_pkg::SEL_W-1:0]; // [R6]
    end
  end

  // Bus-side registers: system reset only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ff <= BUS_RST; // [R7]
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  // Core registers keep time through system reset and standby.
  always_ff @(posedge hclk or negedge backup_rstn) begin
    if (!backup_rstn) begin
      bk_ff <= BK_RST; // [R8] [R9]
    end else begin
      bk_ff <= nxt_bk;
    end
  end

  assign hreadyout    = bus_ff.rdy;
  assign hresp        = bus_ff.err;
  assign hrdata       = bus_ff.rdata;
  assign irq_second   = bus_ff.irq[bdtc_pkg::BIT_SEC];
  assign irq_alarm    = bus_ff.irq[bdtc_pkg::BIT_ALR];
  assign irq_overflow = bus_ff.irq[bdtc_pkg::BIT_OVF];

  ////////////////////////////////////////////////////////////////////////
  // Checks on the design's own behaviour.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !backup_rstn);

  a_second_flag: assert property ( // [R16]
    roll |=> bus_ff.flag[bdtc_pkg::BIT_SEC] &&
             (irq_second || !bus_ff.en[bdtc_pkg::BIT_SEC]))
    else $error("Second flag or interrupt missing.");
  a_wrap_flag: assert property ( // [R15]
    ev[bdtc_pkg::BIT_OVF] && !apply |=>
      bus_ff.flag[bdtc_pkg::BIT_OVF] && (bk_ff.cnt == '0))
    else $error("Overflow not flagged on wrap.");
  a_alarm_flag: assert property ( // [R13]
    roll && (bk_ff.cnt == bk_ff.alr) |=> bus_ff.flag[bdtc_pkg::BIT_ALR])
    else $error("Alarm flag missing.");
  a_count_step: assert property ( // [R17]
    roll && !apply |=>
      (bk_ff.cnt == $past(bk_ff.cnt) + 32'h1) &&
      (bk_ff.div == $past(bk_ff.prl)))
    else $error("Counter or prescaler step wrong.");
  a_chain_hold: assert property ( // [R1]
    !core_tick && !(bus_ff.wr && bus_ff.widx == bdtc_pkg::IDX_CLKSEL)
      |=> $stable(bk_ff))
    else $error("Core changed without a tick.");
  a_apply_count: assert property ( // [R4]
    apply && bus_ff.pend[bdtc_pkg::PEND_CNT] |=>
      (bk_ff.cnt == $past(bus_ff.stg_cnt)) && !busy)
    else $error("Staged counter not applied.");
  a_locked_stage: assert property ( // [R10]
    bus_ff.wr && !backup_write_unlock && !busy |=> $stable(bus_ff.pend))
    else $error("Locked write was staged.");
  a_busy_enable: assert property ( // [R19]
    bus_ff.wr && busy && (bus_ff.widx == bdtc_pkg::IDX_ENABLE)
      |=> $stable(bus_ff.en))
    else $error("Enable written during update.");
  a_irq_gate: assert property ( // [R21]
    bus_ff.irq == (bus_ff.flag & bus_ff.en))
    else $error("Interrupt differs from flag and enable.");
  a_start_update: assert property ( // [R18]
    $rose(busy) |-> !apply ##1 (busy && !apply) ##1 (busy && !apply))
    else $error("Update applied too early.");

  c_apply:    cover property (apply);
  c_alarm:    cover property (ev[bdtc_pkg::BIT_ALR] ##1 irq_alarm);
  c_overflow: cover property (ev[bdtc_pkg::BIT_OVF]);
  c_second:   cover property ($rose(irq_second));

endmodule : bdtc_core

/* verilog/bdtc_unused_marker.sv */
// Intentionally empty compilation unit.

/* verification/bdtc_osc_model.sv */
// Oscillator model that drives the three tick source inputs of the core.
`timescale 1ns/10ps
module bdtc_osc_model (
  input  wire logic hclk,                     // Bus clock.
  output logic      fast_external_oscillator, // Fast source level.
  output logic      slow_external_oscillator, // Slow external level.
  output logic      slow_internal_oscillator  // Slow internal level.
);
  ////////////////////////////////////////////////////////////////////////
  // A free divider of the bus clock; no source toggles faster than a
  // quarter of it, so every level lasts at least two bus cycles.
  logic [3:0] div_ff = 4'h0; // Free-running phase counter.

  // The divider advances on every rising bus clock edge.
  always @(posedge hclk) begin
    div_ff <= div_ff + 4'h1;
  end

  // Each source is a divider tap at or below a quarter of the bus rate.
  assign slow_internal_oscillator = div_ff[1];
  assign slow_external_oscillator = div_ff[2];
  assign fast_external_oscillator = ~div_ff[1];
endmodule : bdtc_osc_model

/* verification/testbench.sv */
// Self-checking bench for the time counter through its register bus.
`timescale 1ns/10ps
module testbench;
  ////////////////////////////////////////////////////////////////////////
  // Byte addresses are four times the register indices.
  localparam logic [7:0] A_EN  = {3'h0, bdtc_pkg::IDX_ENABLE, 2'h0};
  localparam logic [7:0] A_ST  = {3'h0, bdtc_pkg::IDX_STATUS, 2'h0};
  localparam logic [7:0] A_PRL = {3'h0, bdtc_pkg::IDX_PRESC, 2'h0};
  localparam logic [7:0] A_DIV = {3'h0, bdtc_pkg::IDX_DIVIDER, 2'h0};
  localparam logic [7:0] A_CNT = {3'h0, bdtc_pkg::IDX_COUNT, 2'h0};
  localparam logic [7:0] A_ALR = {3'h0, bdtc_pkg::IDX_ALARM, 2'h0};
  localparam logic [7:0] A_SEL = {3'h0, bdtc_pkg::IDX_CLKSEL, 2'h0};
  logic        hclk, hresetn, backup_rstn, hsel, hwrite;  // Bus controls.
  logic [7:0]  haddr;                                     // Byte address.
  logic [1:0]  htrans;                                    // Transfer type.
  logic [2:0]  hsize;                                     // Transfer size.
  logic [31:0] hwdata, hrdata, rd_q, c1;                  // Data words.
  logic        hreadyout, hresp, backup_write_unlock;     // Bus status.
  logic        fosc, seosc, siosc, irq_s, irq_a, irq_o;   // Pins.
  logic [2:0]  irq_q;                                     // Sampled irqs.
  wire         hready = hreadyout;                        // One slave.
  int          n_mismatch, samples_checked;               // Counters.

  bdtc_core bdtc_core_inst (.hclk(hclk), .hresetn(hresetn),
    .backup_rstn(backup_rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .backup_write_unlock(backup_write_unlock),
    .fast_external_oscillator(fosc), .slow_external_oscillator(seosc),
    .slow_internal_oscillator(siosc), .irq_second(irq_s),
    .irq_alarm(irq_a), .irq_overflow(irq_o));

  bdtc_osc_model bdtc_osc_model_inst (.hclk(hclk),
    .fast_external_oscillator(fosc), .slow_external_oscillator(seosc),
    .slow_internal_oscillator(siosc));

  // The bus clock runs at 25 MHz.
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Compares a seen word with the expected one and counts both.
  task check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask : check

  // Waits for hready mid-cycle, so the sample never races the edge.
  task wait_rdy;
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      finish_test;
    end
    rd_q = hrdata;
    @(posedge hclk);
  endtask : wait_rdy

  // One single word transfer: address phase, then data phase.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= bdtc_pkg::SIZE_WORD;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(nm, rd_q, e);
    check("resp", {31'h0, hresp}, 32'h0);
  endtask : rd_chk

  // Polls the write-done bit; a stuck update ends the run.
  task wait_done;
    int i;
    for (i = 0; i < 50; i++) begin
      xfer(1'b0, A_ST, 32'h0);
      if (rd_q[bdtc_pkg::BIT_DONE] === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      finish_test;
    end
  endtask : wait_done

  // Picks a tick source, lets it settle, then counts steps over a gap.
  task rate_chk(input logic [1:0] s, input int gap, input logic [31:0] n);
    wr(A_SEL, {30'h0, s});
    repeat (16) @(posedge hclk);
    xfer(1'b0, A_CNT, 32'h0);
    c1 = rd_q;
    repeat (gap - 2) @(posedge hclk);
    rd_chk("rate", A_CNT, c1 + n);
  endtask : rate_chk

  // Waits for one interrupt line, bit 0 second, 1 alarm, 2 overflow.
  task wait_irq(input int b);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge hclk);
      irq_q = {irq_o, irq_a, irq_s};
      if (irq_q[b] === 1'b1) break;
    end
    if (i == 400) begin
      n_mismatch++;
      finish_test;
    end
    @(posedge hclk);
  endtask : wait_irq

  // Samples the interrupt lines two cycles after a mask or clear.
  task irq_chk(input string nm, input logic [2:0] e);
    repeat (2) @(negedge hclk);
    check(nm, {29'h0, irq_o, irq_a, irq_s}, {29'h0, e});
    @(posedge hclk);
  endtask : irq_chk

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; both resets are held for ten cycles at the start.
  initial begin
    hresetn = 1'b0;
    backup_rstn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = bdtc_pkg::SIZE_WORD;
    hwdata = 32'h0;
    backup_write_unlock = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    backup_rstn <= 1'b1;
    @(posedge hclk);
    rd_chk("status", A_ST, 32'h20);
    rd_chk("count", A_CNT, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'h0);
    // Still locked: neither select nor staged values may change.
    wr(A_SEL, 32'h1);
    rd_chk("sel locked", A_SEL, 32'h3);
    wr(A_ST, 32'h10);
    wr(A_PRL, 32'h5);
    wr(A_ST, 32'h0);
    rd_chk("prl locked", A_PRL, 32'h0);
    // Unlocked: pick the fast toggling slow internal source.
    backup_write_unlock <= 1'b1;
    wr(A_SEL, {30'h0, bdtc_pkg::SEL_SLOW_INT});
    rd_chk("sel", A_SEL, 32'h1);
    // Stage a period of two ticks and a time just before the wrap.
    wr(A_ST, 32'h10);
    wr(A_PRL, 32'h1);
    wr(A_CNT, 32'hfffffffe);
    wr(A_ALR, 32'hffffffff);
    rd_chk("prl staged", A_PRL, 32'h0);
    wr(A_ST, 32'h0);
    xfer(1'b0, A_ST, 32'h0);
    check("busy", {31'h0, rd_q[bdtc_pkg::BIT_DONE]}, 32'h0);
    // An enable write during the update must be ignored.
    wr(A_EN, 32'h7);
    wait_done;
    rd_chk("prl", A_PRL, 32'h1);
    rd_chk("set time", A_CNT, 32'hfffffffe);
    rd_chk("en frozen", A_EN, 32'h0);
    wr(A_EN, 32'h7);
    // Alarm and wrap land on the same step, the second with them.
    wait_irq(2);
    check("irqs", {29'h0, irq_q}, 32'h7);
    rd_chk("wrapped", A_CNT, 32'h0);
    rd_chk("flags", A_ST, 32'h27);
    wr(A_EN, 32'h0);
    irq_chk("masked", 3'h0);
    wr(A_ST, 32'h0);
    wr(A_EN, 32'h4);
    irq_chk("cleared", 3'h0);
    wr(A_EN, 32'h1);
    wait_irq(0);
    check("second only", {29'h0, irq_q}, 32'h1);
    // A period is two ticks of four bus cycles: two steps in 16 cycles.
    rate_chk(bdtc_pkg::SEL_SLOW_INT, 16, 32'h2);
    // System reset clears the bus side only.
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("en after sys", A_EN, 32'h0);
    rd_chk("prl kept", A_PRL, 32'h1);
    rd_chk("sel kept", A_SEL, 32'h1);
    xfer(1'b0, A_CNT, 32'h0);
    check("time kept", {31'h0, rd_q != 32'h0}, 32'h1);
    // Slow external ticks every 8 cycles, fast every 512 after /128.
    rate_chk(bdtc_pkg::SEL_SLOW_EXT, 32, 32'h2);
    rate_chk(bdtc_pkg::SEL_FAST_DIV, 1024, 32'h1);
    // Backup reset clears the core and stops it.
    backup_rstn <= 1'b0;
    repeat (3) @(posedge hclk);
    backup_rstn <= 1'b1;
    @(posedge hclk);
    rd_chk("count bk", A_CNT, 32'h0);
    rd_chk("prl bk", A_PRL, 32'h0);
    rd_chk("sel bk", A_SEL, 32'h3);
    rd_chk("div bk", A_DIV, 32'h0);
    finish_test;
  end
endmodule : testbench
